/* File: adc_cfg.svh */
// Constants for the converter configuration serial port.
`ifndef ADC_CFG_SVH
`define ADC_CFG_SVH
`define WORD_BITS 16
`define ADDR_BITS 5
`define DATA_BITS 11
`define CNT_LAST 4'hF
`define ADDR_PWR 5'h00
`define ADDR_TIMING 5'h04
`define ADDR_ORDER 5'h09
`define ADDR_FMT 5'h0A
`define ADDR_CUST_LO 5'h0B
`define ADDR_FINE_HI 5'h0C
`define ADDR_LVDS 5'h0E
`define ADDR_CMOS 5'h0F
`define BIT_OBUF_PDN 10
`define BIT_COARSE 9
`define BIT_LVDS 8
`define BIT_REF 5
`define BIT_SWRST 4
`define BIT_CLKOUT_PDN 2
`define BIT_STBY 0
`define BIT_DATA_POSN 10
`define BIT_CLK_EDGE 9
`define BIT_CLK_POSN 8
`define BIT_BYTEWISE 10
`define BIT_FMT 10
`define PAT_HI 7
`define PAT_LO 5
`define MASK_PWR 11'h735
`define MASK_TIMING 11'h700
`define MASK_ORDER 11'h400
`define MASK_FMT 11'h4E0
`define MASK_CUST_LO 11'h7F0
`define MASK_FINE_HI 11'h71F
`define MASK_LVDS 11'h3FF
`define MASK_CMOS 11'h0F0
`define REG_RESET 11'h000
`define LVL_LOW 2'h0
`define LVL_38 2'h1
`define LVL_58 2'h2
`define LVL_FULL 2'h3
`define PAT_RAMP 3'h4
`define PAT_CUSTOM 3'h5
`endif

/* File: adc_pkg.sv */
// Types shared by the configuration serial port.
package adc_pkg;
	typedef struct packed {
		logic [4:0] addr;
		logic [10:0] data;
	} cfg_word_t;
	typedef struct packed {
		logic obuf_pdn;
		logic coarse_gain;
		logic lvds_sel;
		logic ext_ref;
		logic clkout_pdn;
		logic stby;
		logic straight_bin;
		logic global_pdn;
	} mode_t;
	typedef struct packed {
		logic data_posn;
		logic clk_edge;
		logic clk_posn;
		logic bytewise;
		logic [2:0] pattern;
	} timing_t;
endpackage

/* File: pin_sync.sv */
// Two-stage synchroniser for one level from outside the clock domain.
`timescale 1ns/1ps
`default_nettype none
module pin_sync (
	input wire logic clk_in,
	input wire logic rstn_in,
	input wire logic ce_in,
	input wire logic d_in,
	output logic q_out
);
	logic meta;
	always_ff @(posedge clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			meta <= 1'b0;
			q_out <= 1'b0;
		end else if (ce_in) begin
			meta <= d_in;
			q_out <= meta;
		end
	end
endmodule // pin_sync
`default_nettype wire

/* File: adc_config_serial_port.sv */
// Serial and parallel configuration front end with the control register bank.
//
// Summary of operation
// - Reset pin low makes select, data and clock pins a serial register port.
// - Reset pin tied high turns those pins into level-coded parallel mode controls.
// - Parallel mode clock pin level picks reference source and coarse gain.
// - Parallel mode select pin level picks data format and output interface.
// - Parallel mode data and power-down pins together pick the power state.
// - Data shifts in only while select is low, sampled on clock falling edges.
// - Every 16th falling edge commits the word; several words per select period.
// - Bits past the last whole 16-bit word are discarded.
// - Each word is a 5-bit address then 11 data bits.
// - Port works from a few hertz up to 20 MHz with any duty cycle.
// - Software reset bit restores defaults and then clears itself.
// - One write updates every field of the addressed register at once.
// - Register 00 holds buffer, gain, interface, reference, reset, clock and standby bits.
// - Register 04 holds data position, capture edge and clock position controls.
// - Register 09 holds the bit-wise or byte-wise DDR ordering choice.
// - Register 0A holds data format and a three-bit test pattern selector.
// - Pattern codes 000 to 101 defined; 110 and 111 unused.
// - Ordering choice steers even/odd or low/high split of DDR output bits.
// - Clock position delays clock 400 ps; data position delays data half cycle.
`timescale 1ns/1ps
`default_nettype none
`include "adc_cfg.svh"
module adc_config_serial_port
	import adc_pkg::*;
(
	input wire logic clk_in,
	input wire logic rstn_in,
	input wire logic ce_in,
	input wire logic hw_reset_in,
	input wire logic serial_select_n_in,
	input wire logic serial_clock_in,
	input wire logic serial_data_in,
	input wire logic power_down_in,
	input wire logic [1:0] clock_pin_level_in,
	input wire logic [1:0] select_pin_level_in,
	output logic parallel_mode_out,
	output mode_t mode_out,
	output timing_t timing_out,
	output logic [6:0] custom_low_out,
	output logic [4:0] custom_high_out,
	output logic [2:0] fine_gain_out,
	output logic [9:0] lvds_drive_out,
	output logic [3:0] cmos_drive_out
);
	////////////////////////////////////////////////////////////////////////
	// Every pin is asynchronous to clk_in, so each passes two flip-flops first.
	logic rst_s, sel_n_s, sclk_s, sdat_s, pdn_s;
	pin_sync u_sync_rst (.clk_in(clk_in), .rstn_in(rstn_in), .ce_in(ce_in), .d_in(hw_reset_in), .q_out(rst_s));
	pin_sync u_sync_sel (.clk_in(clk_in), .rstn_in(rstn_in), .ce_in(ce_in), .d_in(serial_select_n_in),
		.q_out(sel_n_s));
	pin_sync u_sync_clk (.clk_in(clk_in), .rstn_in(rstn_in), .ce_in(ce_in), .d_in(serial_clock_in),
		.q_out(sclk_s));
	pin_sync u_sync_dat (.clk_in(clk_in), .rstn_in(rstn_in), .ce_in(ce_in), .d_in(serial_data_in),
		.q_out(sdat_s));
	pin_sync u_sync_pdn (.clk_in(clk_in), .rstn_in(rstn_in), .ce_in(ce_in), .d_in(power_down_in),
		.q_out(pdn_s));

	// The level inputs are slow straps; they are resynchronised as a bus and read every cycle with no stability check.
	logic [1:0] clk_lvl_m, clk_lvl, sel_lvl_m, sel_lvl;
	always_ff @(posedge clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			clk_lvl_m <= `LVL_LOW;
			clk_lvl <= `LVL_LOW;
			sel_lvl_m <= `LVL_LOW;
			sel_lvl <= `LVL_LOW;
		end else if (ce_in) begin
			clk_lvl_m <= clock_pin_level_in;
			clk_lvl <= clk_lvl_m;
			sel_lvl_m <= select_pin_level_in;
			sel_lvl <= sel_lvl_m;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Edge finding on the sampled serial clock; with 40 MHz sampling the port is good to about 20 MHz.
	logic sclk_d, rst_d;
	always_ff @(posedge clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			sclk_d <= 1'b0;
			rst_d <= 1'b0;
		end else if (ce_in) begin
			sclk_d <= sclk_s;
			rst_d <= rst_s;
		end
	end
	// A reset pin held high for a while is taken as parallel mode; a short pulse only resets the bank.
	logic [3:0] high_cnt;
	logic parallel;
	wire serial_mode = !parallel;
	wire fall = sclk_d && !sclk_s;
	wire shift_en = serial_mode && !rst_s && !sel_n_s && fall;
	wire rst_pulse_end = rst_d && !rst_s;

	always_ff @(posedge clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			high_cnt <= 4'h0;
			parallel <= 1'b0;
		end else if (ce_in) begin
			if (!rst_s)
				high_cnt <= 4'h0;
			else if (high_cnt != `CNT_LAST)
				high_cnt <= high_cnt + 4'h1;
			parallel <= rst_s && (high_cnt == `CNT_LAST);
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Shift register and bit counter.
	logic [15:0] shreg;
	logic [3:0] bit_cnt;
	wire [15:0] next_shreg = {shreg[14:0], sdat_s};
	wire word_done = shift_en && (bit_cnt == `CNT_LAST);
	cfg_word_t word;
	assign word = next_shreg;

	always_ff @(posedge clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			shreg <= 16'h0000;
			bit_cnt <= 4'h0;
		end else if (ce_in) begin
			if (sel_n_s || !serial_mode)
				bit_cnt <= 4'h0;
			else if (shift_en) begin
				shreg <= next_shreg;
				bit_cnt <= bit_cnt + 4'h1;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Register bank. Unused bits are masked so they always read as zero in the bank.
	logic [10:0] r_pwr, r_tim, r_ord, r_fmt, r_clo, r_fhi, r_lvds, r_cmos;
	wire wr = word_done;
	wire swrst = wr && (word.addr == `ADDR_PWR) && word.data[`BIT_SWRST];
	wire bank_clr = swrst || rst_pulse_end || rst_s && !parallel;
	always_ff @(posedge clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			r_pwr <= `REG_RESET;
			r_tim <= `REG_RESET;
			r_ord <= `REG_RESET;
			r_fmt <= `REG_RESET;
			r_clo <= `REG_RESET;
			r_fhi <= `REG_RESET;
			r_lvds <= `REG_RESET;
			r_cmos <= `REG_RESET;
		end else if (ce_in) begin
			if (bank_clr) begin
				// Software reset leaves its own bit clear, so it self-clears.
				r_pwr <= `REG_RESET;
				r_tim <= `REG_RESET;
				r_ord <= `REG_RESET;
				r_fmt <= `REG_RESET;
				r_clo <= `REG_RESET;
				r_fhi <= `REG_RESET;
				r_lvds <= `REG_RESET;
				r_cmos <= `REG_RESET;
			end else if (wr) begin
				unique case (word.addr)
					`ADDR_PWR: r_pwr <= word.data & `MASK_PWR;
					`ADDR_TIMING: r_tim <= word.data & `MASK_TIMING;
					`ADDR_ORDER: r_ord <= word.data & `MASK_ORDER;
					`ADDR_FMT: r_fmt <= word.data & `MASK_FMT;
					`ADDR_CUST_LO: r_clo <= word.data & `MASK_CUST_LO;
					`ADDR_FINE_HI: r_fhi <= word.data & `MASK_FINE_HI;
					`ADDR_LVDS: r_lvds <= word.data & `MASK_LVDS;
					`ADDR_CMOS: r_cmos <= word.data & `MASK_CMOS;
					default: ;
				endcase
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Parallel decode of the level-coded pins.
	wire p_coarse = (clk_lvl == `LVL_58) || (clk_lvl == `LVL_FULL);
	wire p_ext_ref = (clk_lvl == `LVL_38) || (clk_lvl == `LVL_58);
	wire p_lvds = (sel_lvl == `LVL_LOW) || (sel_lvl == `LVL_38);
	wire p_sbin = (sel_lvl == `LVL_38) || (sel_lvl == `LVL_58);
	wire p_stby = pdn_s && !sdat_s;
	wire p_obuf = sdat_s && !pdn_s;
	wire p_gpdn = sdat_s && pdn_s;

	// Patterns 110 and 111 are unused and fall back to converter data.
	wire [2:0] pat = r_fmt[`PAT_HI:`PAT_LO];
	wire [2:0] pat_ok = (pat > `PAT_CUSTOM) ? 3'h0 : pat;

	mode_t next_mode;
	timing_t next_timing;
	assign next_mode = parallel ?
		'{obuf_pdn: p_obuf, coarse_gain: p_coarse, lvds_sel: p_lvds, ext_ref: p_ext_ref,
		  clkout_pdn: 1'b0, stby: p_stby, straight_bin: p_sbin, global_pdn: p_gpdn} :
		'{obuf_pdn: r_pwr[`BIT_OBUF_PDN], coarse_gain: r_pwr[`BIT_COARSE], lvds_sel: r_pwr[`BIT_LVDS],
		  ext_ref: r_pwr[`BIT_REF], clkout_pdn: r_pwr[`BIT_CLKOUT_PDN], stby: r_pwr[`BIT_STBY],
		  straight_bin: r_fmt[`BIT_FMT], global_pdn: 1'b0};
	assign next_timing = '{data_posn: r_tim[`BIT_DATA_POSN], clk_edge: r_tim[`BIT_CLK_EDGE],
		clk_posn: r_tim[`BIT_CLK_POSN], bytewise: r_ord[`BIT_BYTEWISE], pattern: pat_ok};

	always_ff @(posedge clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			parallel_mode_out <= 1'b0;
			mode_out <= '0;
			timing_out <= '0;
			custom_low_out <= 7'h00;
			custom_high_out <= 5'h00;
			fine_gain_out <= 3'h0;
			lvds_drive_out <= 10'h000;
			cmos_drive_out <= 4'h0;
		end else if (ce_in) begin
			parallel_mode_out <= parallel;
			mode_out <= next_mode;
			timing_out <= next_timing;
			custom_low_out <= r_clo[10:4];
			custom_high_out <= r_fhi[4:0];
			fine_gain_out <= r_fhi[10:8];
			lvds_drive_out <= r_lvds[9:0];
			cmos_drive_out <= r_cmos[7:4];
		end
	end

	////////////////////////////////////////////////////////////////////////
	a_word_commit: assert property (@(posedge clk_in) disable iff (!rstn_in)
		ce_in && word_done && !bank_clr && word.addr == `ADDR_TIMING |=> r_tim == ($past(next_shreg[10:0]) & `MASK_TIMING))
		else $error("timing register not written");
	a_no_shift_sel: assert property (@(posedge clk_in) disable iff (!rstn_in)
		ce_in && sel_n_s |=> bit_cnt == 4'h0) else $error("counter not cleared");
	a_shift_fall: assert property (@(posedge clk_in) disable iff (!rstn_in)
		ce_in && $changed(shreg) |-> $past(fall) && !$past(sel_n_s)) else $error("shift without edge");
	a_swrst_clear: assert property (@(posedge clk_in) disable iff (!rstn_in)
		ce_in && swrst |=> r_pwr == `REG_RESET && r_fmt == `REG_RESET) else $error("soft reset failed");
	a_bit_zero: assert property (@(posedge clk_in) disable iff (!rstn_in)
		r_pwr[`BIT_SWRST] == 1'b0) else $error("reset bit stuck");
	a_par_gain: assert property (@(posedge clk_in) disable iff (!rstn_in)
		ce_in && parallel && clk_lvl == `LVL_FULL |=> mode_out.coarse_gain && !mode_out.ext_ref)
		else $error("parallel gain wrong");
	a_par_iface: assert property (@(posedge clk_in) disable iff (!rstn_in)
		ce_in && parallel && sel_lvl == `LVL_58 |=> !mode_out.lvds_sel && mode_out.straight_bin)
		else $error("parallel interface wrong");
	a_par_power: assert property (@(posedge clk_in) disable iff (!rstn_in)
		ce_in && parallel && sdat_s && pdn_s |=> mode_out.global_pdn && !mode_out.stby)
		else $error("parallel power wrong");
	a_pattern_ok: assert property (@(posedge clk_in) disable iff (!rstn_in)
		timing_out.pattern <= `PAT_CUSTOM) else $error("unused pattern out");
endmodule // adc_config_serial_port
`default_nettype wire

/* File: serial_host.sv */
// Host side model that drives the three-wire serial configuration port.
`timescale 1ns/1ps
`default_nettype none
module serial_host (
	input wire logic clk_in,
	input wire logic start_in,
	input wire logic [47:0] bits_in,
	input wire logic [5:0] count_in,
	output logic select_n_out,
	output logic sclk_out,
	output logic serial_data_in_out,
	output logic busy_out
);
	int i;
	initial begin
		select_n_out = 1'b1;
		sclk_out = 1'b0;
		serial_data_in_out = 1'b0;
		busy_out = 1'b0;
	end
	////////////////////////////////////////////////////////////////
	// The clock stands low between frames and the data pin is driven back to 0.
	always @(posedge clk_in) begin
		if (start_in === 1'b1 && busy_out === 1'b0) begin
			busy_out <= 1'b1;
			select_n_out <= 1'b0;
			repeat (2) @(posedge clk_in);
			for (i = 0; i < count_in; i++) begin
				sclk_out <= 1'b1;
				serial_data_in_out <= bits_in[47 - i];
				repeat (3) @(posedge clk_in);
				// An uneven duty cycle catches a port that assumes a square clock.
				sclk_out <= 1'b0;
				repeat (5) @(posedge clk_in);
			end
			select_n_out <= 1'b1;
			serial_data_in_out <= 1'b0;
			busy_out <= 1'b0;
		end
	end
endmodule // serial_host
`default_nettype wire

/* File: adc_config_serial_port_tb.sv */
// Self-checking bench for the configuration serial port.
`timescale 1ns/1ps
`default_nettype none
`include "adc_cfg.svh"
module adc_config_serial_port_tb
	import adc_pkg::*;
;
	logic clk_in = 1'b0, rstn_in = 1'b0, ce_in = 1'b1, hw_reset_in = 1'b0;
	logic power_down_in = 1'b0, par_data = 1'b0, go = 1'b0;
	logic [1:0] clk_lvl = 2'h0, sel_lvl = 2'h0;
	logic [47:0] bits = 48'h0;
	logic [5:0] n = 6'h00;
	wire logic sel_n, sclk, hdat, busy, sdat;
	logic parallel_mode;
	mode_t mode;
	timing_t timing;
	logic [6:0] cl;
	logic [4:0] ch;
	logic [2:0] fg;
	logic [9:0] lv;
	logic [3:0] cm;
	logic [10:0] sh [0:31];
	logic [4:0] addrs [10] = '{5'h00, 5'h04, 5'h09, 5'h0A, 5'h0B, 5'h0C, 5'h0E, 5'h0F, 5'h01, 5'h1F};
	int mismatches = 0, n_checks = 0, cycles = 0;
	// In parallel mode the data pin carries a power control level instead of serial bits.
	assign sdat = hw_reset_in ? par_data : hdat;
	serial_host host (.clk_in(clk_in), .start_in(go), .bits_in(bits), .count_in(n), .select_n_out(sel_n),
		.sclk_out(sclk), .serial_data_in_out(hdat), .busy_out(busy));
	adc_config_serial_port dut (.clk_in(clk_in), .rstn_in(rstn_in), .ce_in(ce_in), .hw_reset_in(hw_reset_in),
		.serial_select_n_in(sel_n), .serial_clock_in(sclk), .serial_data_in(sdat), .power_down_in(power_down_in),
		.clock_pin_level_in(clk_lvl), .select_pin_level_in(sel_lvl), .parallel_mode_out(parallel_mode),
		.mode_out(mode), .timing_out(timing), .custom_low_out(cl), .custom_high_out(ch), .fine_gain_out(fg),
		.lvds_drive_out(lv), .cmos_drive_out(cm));
	////////////////////////////////////////////////////////////////
	initial begin
		forever #12.5 clk_in = ~clk_in;
	end
	always @(posedge clk_in) begin
		cycles++;
		if (cycles == 30000) begin
			mismatches++;
			wrap_up;
		end
	end
	////////////////////////////////////////////////////////////////
	function automatic logic [10:0] mask_of(input logic [4:0] a);
		case (a)
			5'h00: mask_of = `MASK_PWR & ~11'h010;
			5'h04: mask_of = `MASK_TIMING;
			5'h09: mask_of = `MASK_ORDER;
			5'h0A: mask_of = `MASK_FMT;
			5'h0B: mask_of = `MASK_CUST_LO;
			5'h0C: mask_of = `MASK_FINE_HI;
			5'h0E: mask_of = `MASK_LVDS;
			5'h0F: mask_of = `MASK_CMOS;
			default: mask_of = 11'h7FF;
		endcase
	endfunction
	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		n_checks++;
		if (seen !== exp) begin
			mismatches++;
			$display("MISMATCH at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic check_bank;
		logic [2:0] p;
		p = (sh[10][7:5] > 3'h5) ? 3'h0 : sh[10][7:5];
		check(16'(mode), 16'({sh[0][10:8], sh[0][5], sh[0][2], sh[0][0], sh[10][10], 1'b0}));
		check(16'(timing), 16'({sh[4][10:8], sh[9][10], p}));
		check({cl, ch, fg, 1'b0}, {sh[11][10:4], sh[12][4:0], sh[12][10:8], 1'b0});
		check({2'h0, lv, cm}, {2'h0, sh[14][9:0], sh[15][7:4]});
		check(16'(parallel_mode), 16'h0000);
	endtask
	task automatic send(input logic [47:0] b, input logic [5:0] k);
		int t;
		bits <= b;
		n <= k;
		go <= 1'b1;
		@(posedge clk_in);
		go <= 1'b0;
		@(posedge clk_in);
		t = 0;
		while (busy === 1'b1 && t < 1000) begin
			@(posedge clk_in);
			t++;
		end
		// A host that never finishes its frame counts as a failure, not a silent pass.
		if (t >= 1000) mismatches++;
		repeat (10) @(posedge clk_in);
	endtask
	task automatic wr(input logic [4:0] a, input logic [10:0] d);
		send({a, d, 32'h0}, 6'h10);
		sh[a] = d;
		if (a == 5'h00 && d[4]) foreach (sh[j]) sh[j] = 11'h000;
		check_bank;
	endtask
	task automatic wrap_up;
		$display("Checks %0d, mismatches %0d", n_checks, mismatches);
		if (mismatches == 0 && n_checks > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	////////////////////////////////////////////////////////////////
	initial begin
		int i;
		logic [4:0] a;
		logic [7:0] m;
		void'($urandom(32'hD0D0));
		foreach (sh[j]) sh[j] = 11'h000;
		repeat (20) @(posedge clk_in);
		rstn_in <= 1'b1;
		repeat (10) @(posedge clk_in);
		check_bank;
		for (i = 0; i < 40; i++) begin
			a = addrs[$urandom % 10];
			wr(a, 11'($urandom) & mask_of(a));
		end
		for (i = 0; i < 8; i++) wr(5'h0A, {1'b1, 2'h0, 3'(i), 5'h00});
		// Two whole words and seven spare bits in one select period; the spare bits must vanish.
		send({5'h0F, 11'h0A0, 5'h0B, 11'h550, 16'h7FFF}, 6'h27);
		sh[15] = 11'h0A0;
		sh[11] = 11'h550;
		check_bank;
		send({5'h0C, 11'h7FF, 32'h0}, 6'h0A);
		check_bank;
		// A whole word sent while the clock enable is low must leave the bank untouched.
		ce_in <= 1'b0;
		send({5'h0C, 11'h71F, 32'h0}, 6'h10);
		ce_in <= 1'b1;
		repeat (10) @(posedge clk_in);
		check_bank;
		wr(5'h0E, 11'h3FF);
		wr(5'h00, 11'h010);
		wr(5'h0C, 11'h71F);
		// Supply ramp is not modelled; the pulse comes long after reset release instead.
		hw_reset_in <= 1'b1;
		repeat (4) @(posedge clk_in);
		hw_reset_in <= 1'b0;
		repeat (10) @(posedge clk_in);
		foreach (sh[j]) sh[j] = 11'h000;
		check_bank;
		hw_reset_in <= 1'b1;
		repeat (40) @(posedge clk_in);
		check(16'(parallel_mode), 16'h0001);
		for (i = 0; i < 4; i++) begin
			clk_lvl <= 2'(i);
			sel_lvl <= 2'(i);
			{par_data, power_down_in} <= 2'(i);
			repeat (10) @(posedge clk_in);
			// Global power-down may also raise the lesser power bits, so those are left open there.
			m = (i == 3) ? 8'h7B : 8'hFF;
			check(16'(mode & m), 16'({i == 2, i > 1, i < 2, i == 1 || i == 2, 1'b0, i == 1, i == 1 || i == 2, i == 3} & m));
		end
		hw_reset_in <= 1'b0;
		par_data <= 1'b0;
		power_down_in <= 1'b0;
		repeat (10) @(posedge clk_in);
		check_bank;
		wrap_up;
	end
endmodule // adc_config_serial_port_tb
`default_nettype wire
